//--- shared/tmt_pkg.sv
// constants and types shared by the timer two block
// Behaviour
// [R1] sixteen-bit counter from readable writable bytes
// [R2] source: divided clock or count pin edges
// [R3] mode decoded from run, baud, capture bits
// [R4] capture copies counter on trigger falling edge
// [R5] capture mode needs select and run set
// [R6] overflow flag set on rollover to zero
// [R7] auto-reload loads register pair on overflow
// [R8] trigger edge also reloads in auto-reload
// [R9] trigger enable clear ignores trigger pin
// [R10] baud selects force auto-reload baud generator
// [R11] baud mode pulses uart, no overflow flag
// [R12] baud mode timer ticks at half clock
// [R13] baud mode trigger edge sets external flag
// [R14] external flag set on triggered capture/reload
// [R15] flags cleared only by software write
// [R16] interrupt while flag set and enabled
// [R17] baud bits choose this or other timer
// [R18] uart bit rate is overflow rate over sixteen
// [R19] high capture byte captures or supplies reload
// [R20] divide select: twelve or one, else ignored
// [R21] pins synchronised, one event per falling edge
`default_nettype none

package tmt_pkg;
  // register addresses on the special-function bus
  localparam logic [7:0] ADDR_CONTROL = 8'hc8;
  localparam logic [7:0] ADDR_CAP_LOW = 8'hca;
  localparam logic [7:0] ADDR_CAP_HIGH = 8'hcb;
  localparam logic [7:0] ADDR_COUNT_LOW = 8'hcc;
  localparam logic [7:0] ADDR_COUNT_HIGH = 8'hcd;
  localparam logic [7:0] ADDR_CLOCK_CONTROL = 8'h8e;
  // control register bit positions
  localparam int BIT_OVERFLOW = 7;
  localparam int BIT_EXTERNAL = 6;
  localparam int BIT_RX_BAUD = 5;
  localparam int BIT_TX_BAUD = 4;
  localparam int BIT_TRIG_EN = 3;
  localparam int BIT_RUN = 2;
  localparam int BIT_SOURCE = 1;
  localparam int BIT_CAPTURE = 0;
  // divide select position in the clock control register
  localparam int BIT_DIVIDE = 5;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [3:0] PRESCALE_TWELVE = 4'hb;
  localparam logic [3:0] UART_DIVIDE = 4'hf;

  typedef enum logic [3:0] {
    MODE_OFF = 4'h1,
    MODE_CAPTURE = 4'h2,
    MODE_RELOAD = 4'h4,
    MODE_BAUD = 4'h8
  } tmt_mode_type;
endpackage : tmt_pkg

`default_nettype wire

//--- hw/tmt_fall_detect.sv
// synchroniser and falling-edge detector for one pin
`default_nettype none

module tmt_fall_detect (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // pin and event
  input wire logic pin,
  output logic fall
);
  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
  } tmt_fd_state_type;

  tmt_fd_state_type s_q;
  tmt_fd_state_type s_d;

  // reset high so a pin already low after reset gives one falling edge
  always_comb begin
    s_d = s_q;
    s_d.meta = pin;
    s_d.sync = s_q.meta;
    s_d.last = s_q.sync;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_q <= 3'b111;
    end else begin
      s_q <= s_d;
    end
  end

  assign fall = s_q.last & ~s_q.sync; // [R21]
endmodule : tmt_fall_detect

`default_nettype wire

//--- hw/tmt_uart_divider.sv
// divides overflow pulses by sixteen into uart bit ticks
`default_nettype none

module tmt_uart_divider (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // overflow in, bit tick out
  input wire logic overflow,
  output logic bit_tick
);
  typedef struct packed {
    logic [3:0] cnt;
    logic tick;
  } tmt_ud_state_type;

  tmt_ud_state_type s_q;
  tmt_ud_state_type s_d;

  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (overflow) begin
      s_d.cnt = s_q.cnt + 4'h1;
      s_d.tick = (s_q.cnt == tmt_pkg::UART_DIVIDE); // [R18]
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign bit_tick = s_q.tick;
endmodule : tmt_uart_divider

`default_nettype wire

//--- hw/tmt_timer.sv
// sixteen-bit capture, auto-reload and baud timer on the sfr bus
`default_nettype none

module tmt_timer (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // special-function-register bus
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  // external pins
  input wire logic external_count_pin,
  input wire logic external_trigger_pin,
  // interrupt
  input wire logic timer_irq_enable,
  output logic timer_irq,
  // uart clocks
  input wire logic other_timer_overflow,
  output logic overflow_pulse,
  output logic rx_bit_tick,
  output logic tx_bit_tick
);
  ////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [7:0] control;
    logic [7:0] clock_control;
    logic [7:0] cap_low;
    logic [7:0] cap_high;
    logic [15:0] count;
    logic [3:0] prescale;
    logic half;
    logic [7:0] rdata;
    logic irq;
    logic ovf_pulse;
    logic rx_tick;
    logic tx_tick;
  } tmt_state_type;

  tmt_state_type s_q;
  tmt_state_type s_d;
  logic count_fall;
  logic trig_fall;
  logic uart_tick;
  tmt_pkg::tmt_mode_type mode;
  logic tick;
  logic trig_evt;
  logic wrap;

  tmt_fall_detect u_count_edge (
    .ref_clk(ref_clk),
    .rst(rst),
    .pin(external_count_pin),
    .fall(count_fall)
  );

  tmt_fall_detect u_trig_edge (
    .ref_clk(ref_clk),
    .rst(rst),
    .pin(external_trigger_pin),
    .fall(trig_fall)
  );

  // the divider counts overflow pulses, which only come in baud mode
  tmt_uart_divider u_divider (
    .ref_clk(ref_clk),
    .rst(rst),
    .overflow(s_q.ovf_pulse),
    .bit_tick(uart_tick)
  );

  ////////////////////////////////////////////////////////////////
  function automatic tmt_pkg::tmt_mode_type decode_mode(input logic [7:0] c);
    if (!c[tmt_pkg::BIT_RUN]) begin
      decode_mode = tmt_pkg::MODE_OFF; // [R3]
    end else if (c[tmt_pkg::BIT_RX_BAUD] | c[tmt_pkg::BIT_TX_BAUD]) begin
      decode_mode = tmt_pkg::MODE_BAUD; // [R10]
    end else if (c[tmt_pkg::BIT_CAPTURE]) begin
      decode_mode = tmt_pkg::MODE_CAPTURE; // [R5]
    end else begin
      decode_mode = tmt_pkg::MODE_RELOAD; // [R3]
    end
  endfunction

  always_comb begin
    mode = decode_mode(s_q.control);
  end

  // trigger gated by enable; baud mode still sees it for the flag
  assign trig_evt = trig_fall & s_q.control[tmt_pkg::BIT_TRIG_EN]; // [R9]

  // count tick selection
  always_comb begin
    tick = 1'b0;
    if (mode != tmt_pkg::MODE_OFF) begin
      if (s_q.control[tmt_pkg::BIT_SOURCE]) begin
        tick = count_fall; // [R2]
      end else if (mode == tmt_pkg::MODE_BAUD) begin
        tick = s_q.half; // [R12]
      end else if (s_q.clock_control[tmt_pkg::BIT_DIVIDE]) begin
        tick = 1'b1; // [R20]
      end else begin
        tick = (s_q.prescale == tmt_pkg::PRESCALE_TWELVE); // [R20]
      end
    end
  end

  assign wrap = tick & (s_q.count == 16'hffff);

  ////////////////////////////////////////////////////////////////
  always_comb begin
    s_d = s_q;
    s_d.ovf_pulse = 1'b0;
    s_d.half = ~s_q.half;
    s_d.prescale = (s_q.prescale == tmt_pkg::PRESCALE_TWELVE) ? 4'h0 : s_q.prescale + 4'h1;

    // counting
    if (tick) begin
      s_d.count = s_q.count + 16'h0001; // [R1]
    end
    if (wrap) begin
      if (mode == tmt_pkg::MODE_BAUD) begin
        s_d.ovf_pulse = 1'b1; // [R11]
      end else begin
        s_d.control[tmt_pkg::BIT_OVERFLOW] = 1'b1; // [R6]
      end
      if (mode != tmt_pkg::MODE_CAPTURE) begin
        s_d.count = {s_q.cap_high, s_q.cap_low}; // [R7] [R10] [R19]
      end
    end

    // software writes; hardware sets below still win over a clear
    if (sfr_wr) begin
      unique case (sfr_addr)
        tmt_pkg::ADDR_CONTROL: s_d.control = sfr_wdata; // [R15]
        tmt_pkg::ADDR_CLOCK_CONTROL: s_d.clock_control = sfr_wdata & 8'h38;
        tmt_pkg::ADDR_CAP_LOW: s_d.cap_low = sfr_wdata;
        tmt_pkg::ADDR_CAP_HIGH: s_d.cap_high = sfr_wdata;
        tmt_pkg::ADDR_COUNT_LOW: s_d.count[7:0] = sfr_wdata; // [R1]
        tmt_pkg::ADDR_COUNT_HIGH: s_d.count[15:8] = sfr_wdata; // [R1]
        default: ;
      endcase
    end
    if (wrap && mode != tmt_pkg::MODE_BAUD && mode != tmt_pkg::MODE_OFF) begin
      s_d.control[tmt_pkg::BIT_OVERFLOW] = 1'b1; // [R6]
    end

    // trigger events
    if (trig_evt && mode != tmt_pkg::MODE_OFF) begin
      unique case (mode)
        tmt_pkg::MODE_CAPTURE: begin
          s_d.cap_low = s_q.count[7:0]; // [R4]
          s_d.cap_high = s_q.count[15:8]; // [R19]
        end
        tmt_pkg::MODE_RELOAD: begin
          s_d.count = {s_q.cap_high, s_q.cap_low}; // [R8]
        end
        default: ;
      endcase
      s_d.control[tmt_pkg::BIT_EXTERNAL] = 1'b1; // [R13] [R14]
    end

    // interrupt request follows flags and enable
    s_d.irq = timer_irq_enable & (s_d.control[tmt_pkg::BIT_OVERFLOW] |
      s_d.control[tmt_pkg::BIT_EXTERNAL]); // [R16]

    // uart clock select per direction
    s_d.rx_tick = s_q.control[tmt_pkg::BIT_RX_BAUD] ? uart_tick : other_timer_overflow; // [R17]
    s_d.tx_tick = s_q.control[tmt_pkg::BIT_TX_BAUD] ? uart_tick : other_timer_overflow; // [R17]

    // read data is registered; unmapped addresses read zero
    s_d.rdata = tmt_pkg::RESET_BYTE;
    if (sfr_rd) begin
      unique case (sfr_addr)
        tmt_pkg::ADDR_CONTROL: s_d.rdata = s_q.control;
        tmt_pkg::ADDR_CLOCK_CONTROL: s_d.rdata = s_q.clock_control;
        tmt_pkg::ADDR_CAP_LOW: s_d.rdata = s_q.cap_low;
        tmt_pkg::ADDR_CAP_HIGH: s_d.rdata = s_q.cap_high;
        tmt_pkg::ADDR_COUNT_LOW: s_d.rdata = s_q.count[7:0];
        tmt_pkg::ADDR_COUNT_HIGH: s_d.rdata = s_q.count[15:8];
        default: s_d.rdata = tmt_pkg::RESET_BYTE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sfr_rdata = s_q.rdata;
  assign timer_irq = s_q.irq;
  assign overflow_pulse = s_q.ovf_pulse;
  assign rx_bit_tick = s_q.rx_tick;
  assign tx_bit_tick = s_q.tx_tick;
endmodule : tmt_timer

`default_nettype wire

//--- verification/tmt_other_timer.sv
// stand-in for the other timer that feeds the uart
`default_nettype none
module tmt_other_timer (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // overflow pulse
  output logic other_timer_overflow
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] cnt_q;
  always_ff @(posedge ref_clk or posedge rst)
    if (rst) cnt_q <= 3'h0;
    else cnt_q <= cnt_q + 3'h1;
  // one cycle in eight, so a stuck or late source shows at once
  assign other_timer_overflow = (cnt_q == 3'h7);
endmodule // tmt_other_timer
`default_nettype wire

//--- verification/tmt_checker.sv
// port assertions for the timer two block
`default_nettype none
module tmt_checker (
  // clock, reset and bus
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_rdata,
  // interrupt and uart
  input wire logic timer_irq_enable,
  input wire logic timer_irq,
  input wire logic other_timer_overflow,
  input wire logic overflow_pulse,
  input wire logic rx_bit_tick,
  input wire logic tx_bit_tick
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [7:0] ctl_q;
  logic wc;
  assign wc = sfr_wr && sfr_addr == 8'hc8;
  // shadow of the control bits that only software changes
  always_ff @(posedge ref_clk or posedge rst)
    if (rst) ctl_q <= 8'h00;
    else if (wc) ctl_q <= sfr_wdata;
  sequence s_wr_rd(logic [7:0] x);
    sfr_wr && sfr_addr == x ##1 !sfr_wr ##1 sfr_rd && sfr_addr == x;
  endsequence
  a_idle_rdata: assert property (!sfr_rd |=> sfr_rdata == 8'h00)
    else $error("read data not idle");
  a_ctrl_back: assert property (s_wr_rd(8'hc8) |=>
    sfr_rdata[5:0] == $past(sfr_wdata[5:0], 3))
    else $error("control readback wrong");
  a_div_back: assert property (s_wr_rd(8'h8e) |=> sfr_rdata[5] == $past(sfr_wdata[5], 3))
    else $error("divide select readback wrong");
  a_irq_gate: assert property (!timer_irq_enable |=> !timer_irq)
    else $error("interrupt while disabled");
  a_flag_hold: assert property (timer_irq && timer_irq_enable && !wc && !$past(wc) |=> timer_irq)
    else $error("flag dropped without write");
  a_pulse_gap: assert property (overflow_pulse |=> !overflow_pulse)
    else $error("overflow faster than half clock");
  a_no_pulse: assert property ((!ctl_q[5] && !ctl_q[4]) [*2] |=> !overflow_pulse)
    else $error("uart pulse outside baud mode");
  a_rx_other: assert property (!ctl_q[5] [*2] |=>
    rx_bit_tick == $past(other_timer_overflow))
    else $error("receive tick not from other timer");
  a_tx_other: assert property (!ctl_q[4] [*2] |=>
    tx_bit_tick == $past(other_timer_overflow))
    else $error("transmit tick not from other timer");
endmodule // tmt_checker
bind tmt_timer tmt_checker tmt_checker_i (.ref_clk, .rst, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd,
  .sfr_rdata, .timer_irq_enable, .timer_irq, .other_timer_overflow, .overflow_pulse, .rx_bit_tick,
  .tx_bit_tick);
`default_nettype wire

//--- verification/tb.sv
// self-checking bench for the timer two block
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk, rst, wr, rd, cp, tp, en, irq, oth, op, rt, tt;
  logic [7:0] a, d, q, b;
  int mismatches, n_tests, n;
  logic [23:0] rows [7] = '{24'hca5a5a, 24'hcba5a5, 24'h8e2020, 24'hc97700, 24'hcc3434,
    24'hcd1212, 24'hc80b0b};
  tmt_timer tmt_timer_i (.ref_clk, .rst, .sfr_addr(a), .sfr_wdata(d), .sfr_wr(wr), .sfr_rd(rd),
    .sfr_rdata(q), .external_count_pin(cp), .external_trigger_pin(tp), .timer_irq_enable(en),
    .timer_irq(irq), .other_timer_overflow(oth), .overflow_pulse(op), .rx_bit_tick(rt),
    .tx_bit_tick(tt));
  tmt_other_timer tmt_other_timer_i (.ref_clk, .rst, .other_timer_overflow(oth));
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////
  task automatic report_and_stop;
    if (mismatches == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    n_tests++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch %0t %h %h", $time, s, e);
    end
  endtask
  task automatic wt(input logic [7:0] x, input logic [7:0] y);
    @(negedge ref_clk);
    a = x;
    d = y;
    wr = 1'b1;
    @(negedge ref_clk);
    wr = 1'b0;
  endtask
  task automatic rc(input logic [7:0] x, input logic [7:0] e);
    @(negedge ref_clk);
    a = x;
    rd = 1'b1;
    @(negedge ref_clk);
    rd = 1'b0;
    chk(q, e);
  endtask
  // six cycles per level so the synchroniser sees each edge once
  task automatic fall(input bit t);
    @(negedge ref_clk);
    if (t) tp = 1'b0;
    else cp = 1'b0;
    repeat (6) @(negedge ref_clk);
    tp = 1'b1;
    cp = 1'b1;
    repeat (6) @(negedge ref_clk);
  endtask
  task automatic wtick(output int c);
    c = 0;
    do begin
      @(negedge ref_clk);
      c++;
    end while (tt !== 1'b1 && c < 300);
    if (c >= 300) begin
      mismatches++;
      report_and_stop();
    end
  endtask
  ////////////////////////////////////////
  initial begin
    mismatches = 0;
    n_tests = 0;
    rst = 1'b1;
    {a, d, wr, rd, en, cp, tp} = 21'h3;
    repeat (16) @(negedge ref_clk);
    rst = 1'b0;
    foreach (rows[k]) rc(rows[k][23:16], 8'h00);
    foreach (rows[k]) begin
      wt(rows[k][23:16], rows[k][15:8]);
      rc(rows[k][23:16], rows[k][7:0]);
    end
    wt(8'hc8, 8'h0f);
    repeat (3) fall(1'b0);
    fall(1'b1);
    rc(8'hca, 8'h37);
    rc(8'hcb, 8'h12);
    rc(8'hc8, 8'h4f);
    wt(8'hca, 8'h00);
    wt(8'hcb, 8'h50);
    wt(8'hc8, 8'h0e);
    fall(1'b1);
    rc(8'hcd, 8'h50);
    rc(8'hc8, 8'h4e);
    wt(8'hc8, 8'h06);
    fall(1'b0);
    fall(1'b1);
    rc(8'hcc, 8'h01);
    rc(8'hc8, 8'h06);
    en = 1'b1;
    wt(8'hcc, 8'hfe);
    wt(8'hcd, 8'hff);
    wt(8'hc8, 8'h05);
    repeat (20) @(negedge ref_clk);
    rc(8'hc8, 8'h85);
    chk({7'h00, irq}, 8'h01);
    repeat (40) @(negedge ref_clk);
    rc(8'hc8, 8'h85);
    en = 1'b0;
    @(negedge ref_clk);
    chk({7'h00, irq}, 8'h00);
    wt(8'hc8, 8'h00);
    rc(8'hc8, 8'h00);
    wt(8'hca, 8'hf0);
    wt(8'hcb, 8'hff);
    wt(8'hcc, 8'hfe);
    wt(8'hcd, 8'hff);
    wt(8'hc8, 8'h04);
    repeat (5) @(negedge ref_clk);
    rc(8'hcd, 8'hff);
    rc(8'hc8, 8'h84);
    wt(8'hca, 8'hff);
    wt(8'hc8, 8'h34);
    wtick(n);
    wtick(n);
    chk(n[7:0], 8'h20);
    chk({7'h00, rt}, 8'h01);
    rc(8'hc8, 8'h34);
    wt(8'hc8, 8'h3c);
    fall(1'b1);
    rc(8'hc8, 8'h7c);
    en = 1'b1;
    @(negedge ref_clk);
    chk({7'h00, irq}, 8'h01);
    // reset in mid-run: flags, reload byte and divide select all go back to zero
    rst = 1'b1;
    repeat (2) @(negedge ref_clk);
    rst = 1'b0;
    chk({7'h00, irq}, 8'h00);
    rc(8'hc8, 8'h00);
    rc(8'hcb, 8'h00);
    rc(8'h8e, 8'h00);
    // divide by twelve: prescaler phase is unknown, so measure ticks over 120 cycles
    wt(8'hc8, 8'h04);
    @(negedge ref_clk);
    a = 8'hcc;
    rd = 1'b1;
    @(negedge ref_clk);
    rd = 1'b0;
    b = q;
    repeat (118) @(negedge ref_clk);
    rc(8'hcc, b + 8'h0a);
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
